// File: rtl/ssch_pkg.sv
/*
 * shared constants and types of the six-channel sample scheduler:
 * link timing, conversion sequencing, output word layout, host register map.
 * assumes both ends run on mclk_in at 250 MHz.
 */
// How it works
// - reset clears results, aborts, reopens sampling
// - host waits after reset before holding
// - busy low thirteen cycles, rises after latch
// - one pair conversion spans sixteen cycles
// - hold fall freezes both channels at once
// - later holds queue behind earlier ones
// - same-cycle holds convert A then B then C
// - holds grouped per conversion clock fall
// - steady low hold starts nothing new
// - repeat pulses ignored until pair converted
// - busy rise returns pair to sampling
// - host waits acquisition time after busy
// - select 010 gives B0, 011 gives B1
// - data pins driven only while selected and read
// - result latched twelve and a half cycles in
// - host holds read strobe long enough
// - host may keep chip select low
// - host never reads during a hold edge
// - select 000-101 channels, 110 cycle, 111 fifo
// - word is valid flag, tag, twelve bits
// - latch waits while read strobe low
// - one request per pair, two channels together
package ssch_pkg;
   // system clock
   localparam int unsigned CLK_NS = 4;
   // structure
   localparam int unsigned NUM_PAIRS = 3;
   localparam int unsigned NUM_CH = 6;
   localparam int unsigned RES_W = 12;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned SEL_W = 3;
   typedef logic [RES_W-1:0] ssch_res_t;
   typedef logic [WORD_W-1:0] ssch_word_t;
   typedef logic [SEL_W-1:0] ssch_sel_t;
   // word layout
   localparam int unsigned WORD_VALID_BIT = 15;
   localparam int unsigned TAG_LSB = 12;
   // select patterns
   localparam ssch_sel_t SEL_LAST_CH = 3'h5;
   localparam ssch_sel_t SEL_CYCLE = 3'h6;
   localparam ssch_sel_t SEL_FIFO = 3'h7;
   // conversion sequence, counted in conversion clock cycles and half cycles
   localparam int unsigned CONV_CYCLES = 13;
   localparam int unsigned LATCH_HALVES = 25;
   localparam int unsigned PERIOD_CYCLES = 16;
   localparam int unsigned BUSY_HALVES = 2 * CONV_CYCLES;
   localparam int unsigned PERIOD_HALVES = 2 * PERIOD_CYCLES;
   // link timing in ns, with cycle counts (least times round up)
   localparam int unsigned HOLD_LOW_NS = 20;
   localparam int unsigned HOLD_HIGH_NS = 15;
   localparam int unsigned RESET_LOW_NS = 20;
   localparam int unsigned FIRST_HOLD_NS = 20;
   localparam int unsigned ACQ_NS = 175;
   localparam int unsigned ADDR_SETUP_NS = 10;
   localparam int unsigned READ_LOW_NS = 50;
   localparam int unsigned READ_HIGH_NS = 30;
   localparam int unsigned CONV_PERIOD_NS = 125;
   localparam int unsigned HOLD_LOW_CYC = (HOLD_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned HOLD_HIGH_CYC = (HOLD_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned RESET_LOW_CYC = (RESET_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned FIRST_HOLD_CYC = (FIRST_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned ACQ_CYC = (ACQ_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned ADDR_SETUP_CYC = (ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned READ_LOW_CYC = (READ_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned READ_HIGH_CYC = (READ_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned CONV_HALF_CYC = (CONV_PERIOD_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
   // host register map
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_READ = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam int unsigned CTRL_RESET_BIT = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: rtl/ssch_link_if.sv
/*
 * pin-level link between the converter control end and its host.
 * assumes both ends share mclk_in; no tristate here, oe says who drives.
 */
`timescale 1ns/10ps
`default_nettype none
interface ssch_link_if;
   logic [ssch_pkg::NUM_PAIRS-1:0] pair_sample_request_n;
   logic reset_n;
   logic conv_clk;
   logic [ssch_pkg::SEL_W-1:0] source_select;
   logic cs_n;
   logic rd_n;
   logic busy_n;
   logic [ssch_pkg::WORD_W-1:0] data;
   logic data_oe;
   // converter end
   modport dev (
      input pair_sample_request_n, reset_n, conv_clk, source_select, cs_n, rd_n,
      output busy_n, data, data_oe
   );
   // host end
   modport host (
      output pair_sample_request_n, reset_n, conv_clk, source_select, cs_n, rd_n,
      input busy_n, data, data_oe
   );
endinterface
`default_nettype wire

// File: rtl/ssch_device.sv
/*
 * converter control end: pin filtering, hold capture, pair queue,
 * conversion sequencing on the link conversion clock, result registers
 * and the read port.
 * assumes the host paces holds and reads; all pins are asynchronous
 * to mclk_in and pass a three-stage filter before use.
 */
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ssch_device (
   // system
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // link
   ssch_link_if.dev link,
   // analog stand-in, one value per channel, pair x at 2x and 2x+1
   input wire logic [ssch_pkg::NUM_CH-1:0][ssch_pkg::RES_W-1:0] sample_in,
   // pairs currently held
   output logic [ssch_pkg::NUM_PAIRS-1:0] held_out
);
   import ssch_pkg::*;

   localparam int unsigned PIN_W = 10;
   localparam logic [PIN_W-1:0] PIN_IDLE = 10'h2c7;
   localparam int unsigned P_RST = 9;
   localparam int unsigned P_CLK = 8;
   localparam int unsigned P_CS = 7;
   localparam int unsigned P_RD = 6;
   localparam int unsigned P_SEL = 3;

   typedef enum logic [1:0] {
      SSCH_IDLE = 2'b00,
      SSCH_CONVERT = 2'b01,
      SSCH_SETTLE = 2'b10
   } ssch_cv_t;

   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] s1_q, s2_q, s3_q, filt_q, prev_q;
   logic link_rst;
   logic clk_rise, clk_fall;
   logic [NUM_PAIRS-1:0] hold_fall;
   logic [NUM_PAIRS-1:0] take;
   logic [NUM_PAIRS-1:0] seen_q, queued_q;
   logic [NUM_PAIRS-1:0] push_set;
   logic [1:0] q_slot_q [NUM_PAIRS];
   logic [1:0] q_slot_d [NUM_PAIRS];
   logic [1:0] q_cnt_q, q_cnt_d;
   logic start_conv;
   ssch_cv_t cv_q;
   logic [5:0] half_q;
   logic [1:0] cur_q;
   logic latched_q;
   logic do_latch, do_finish;
   ssch_res_t held_val_q [NUM_CH];
   ssch_res_t res_q [NUM_CH];
   logic [NUM_CH-1:0] valid_q;
   logic busy_n_q;
   ssch_word_t data_q;
   logic data_oe_q;
   ssch_sel_t sel;

   assign pin_raw = {link.reset_n, link.conv_clk, link.cs_n, link.rd_n,
                     link.source_select, link.pair_sample_request_n};

   // three-stage pin filter; a level moves once stages two and three agree
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_q <= PIN_IDLE;
         s2_q <= PIN_IDLE;
         s3_q <= PIN_IDLE;
         filt_q <= PIN_IDLE;
         prev_q <= PIN_IDLE;
      end else if (ce_in) begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= (s3_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
         prev_q <= filt_q;
      end
   end

   // filtered pins and their edges
   assign link_rst = ~filt_q[P_RST];
   assign clk_rise = filt_q[P_CLK] & ~prev_q[P_CLK];
   assign clk_fall = ~filt_q[P_CLK] & prev_q[P_CLK];
   assign hold_fall = prev_q[NUM_PAIRS-1:0] & ~filt_q[NUM_PAIRS-1:0];
   assign sel = filt_q[P_SEL +: SEL_W];
   // a fall in its own finishing cycle still counts: the set beats the clear
   assign take = hold_fall & ~(seen_q & ~(do_finish ? 3'(1 << cur_q) : 3'h0));

   // a pair fires once until its conversion ends; steady low is no edge
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         seen_q <= '0;
      end else if (ce_in) begin
         if (link_rst) begin
            seen_q <= '0;
         end else begin
            for (int p = 0; p < NUM_PAIRS; p++) begin
               if (take[p]) begin
                  seen_q[p] <= 1'b1;
               end else if (do_finish && cur_q == 2'(p)) begin
                  seen_q[p] <= 1'b0;
               end
            end
         end
      end
   end

   // both channels of a pair freeze together at the hold edge
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int c = 0; c < NUM_CH; c++) begin
            held_val_q[c] <= '0;
         end
      end else if (ce_in) begin
         for (int p = 0; p < NUM_PAIRS; p++) begin
            if (take[p] && !link_rst) begin
               held_val_q[2*p] <= sample_in[2*p];
               held_val_q[2*p+1] <= sample_in[2*p+1];
            end
         end
      end
   end

   // arrivals join the queue at a conversion clock fall, lowest pair first
   assign push_set = clk_fall ? (seen_q & ~queued_q) : '0;
   assign start_conv = clk_rise && (q_cnt_q != 2'h0) && busy_n_q &&
                       (cv_q == SSCH_IDLE || half_q == 6'(PERIOD_HALVES));

   // queue update: pop the head on start, then append the new group in order
   always_comb begin
      logic [1:0] n;
      n = q_cnt_q;
      for (int i = 0; i < NUM_PAIRS; i++) begin
         q_slot_d[i] = q_slot_q[i];
      end
      if (start_conv) begin
         for (int i = 0; i < NUM_PAIRS - 1; i++) begin
            q_slot_d[i] = q_slot_q[i+1];
         end
         n = n - 2'h1;
      end
      for (int p = 0; p < NUM_PAIRS; p++) begin
         if (push_set[p]) begin
            q_slot_d[n] = 2'(p);
            n = n + 2'h1;
         end
      end
      q_cnt_d = n;
   end

   // queue registers; reset drops every scheduled conversion
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q_cnt_q <= '0;
         queued_q <= '0;
         for (int i = 0; i < NUM_PAIRS; i++) begin
            q_slot_q[i] <= '0;
         end
      end else if (ce_in) begin
         if (link_rst) begin
            q_cnt_q <= '0;
            queued_q <= '0;
         end else begin
            q_cnt_q <= q_cnt_d;
            for (int i = 0; i < NUM_PAIRS; i++) begin
               q_slot_q[i] <= q_slot_d[i];
            end
            queued_q <= (queued_q | push_set) & ~(do_finish ? 3'(1 << cur_q) : 3'h0);
         end
      end
   end

   // latch deferred while the read strobe is low; busy follows the latch
   assign do_latch = (cv_q == SSCH_CONVERT) && !latched_q &&
                     half_q >= 6'(LATCH_HALVES) && filt_q[P_RD];
   assign do_finish = (cv_q == SSCH_CONVERT) && latched_q && !busy_n_q &&
                      half_q >= 6'(BUSY_HALVES);

   // conversion sequencer on filtered conversion clock edges
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cv_q <= SSCH_IDLE;
         half_q <= '0;
         cur_q <= '0;
         latched_q <= 1'b0;
         busy_n_q <= 1'b1;
      end else if (ce_in) begin
         if (link_rst) begin
            cv_q <= SSCH_IDLE;
            busy_n_q <= 1'b1;
            latched_q <= 1'b0;
            half_q <= '0;
         end else if (start_conv) begin
            cv_q <= SSCH_CONVERT;
            cur_q <= q_slot_q[0];
            half_q <= '0;
            latched_q <= 1'b0;
            busy_n_q <= 1'b0;
         end else begin
            if ((clk_rise || clk_fall) && half_q < 6'(PERIOD_HALVES)) begin
               half_q <= half_q + 6'h1;
            end
            if (do_latch) begin
               latched_q <= 1'b1;
            end
            if (do_finish) begin
               busy_n_q <= 1'b1;
               cv_q <= SSCH_SETTLE;
            end
            if (cv_q == SSCH_SETTLE && half_q == 6'(PERIOD_HALVES)) begin
               cv_q <= SSCH_IDLE;
            end
         end
      end
   end

   // result registers, cleared by the link reset
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         valid_q <= '0;
         for (int c = 0; c < NUM_CH; c++) begin
            res_q[c] <= '0;
         end
      end else if (ce_in) begin
         if (link_rst) begin
            valid_q <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
               res_q[c] <= '0;
            end
         end else if (do_latch) begin
            res_q[2*cur_q] <= held_val_q[2*cur_q];
            res_q[2*cur_q+1] <= held_val_q[2*cur_q+1];
            valid_q[2*cur_q] <= 1'b1;
            valid_q[2*cur_q+1] <= 1'b1;
         end
      end
   end

   // read port; cycle and fifo patterns return an empty word
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         data_q <= '0;
         data_oe_q <= 1'b0;
      end else if (ce_in) begin
         data_oe_q <= ~filt_q[P_CS] & ~filt_q[P_RD];
         if (sel <= SEL_LAST_CH) begin
            data_q <= '0;
            data_q[WORD_VALID_BIT] <= valid_q[sel];
            data_q[TAG_LSB +: SEL_W] <= sel;
            data_q[RES_W-1:0] <= res_q[sel];
         end else begin
            data_q <= '0;
         end
      end
   end

   assign link.busy_n = busy_n_q;
   assign link.data = data_q;
   assign link.data_oe = data_oe_q;
   assign held_out = seen_q;
endmodule
`default_nettype wire

// File: rtl/ssch_host.sv
/*
 * host end: AXI4-Lite register slave that drives hold pulses, the link
 * reset, the conversion clock and paced read cycles.
 * assumes one AXI write and one read in flight; link inputs are filtered.
 */
`timescale 1ns/10ps
`default_nettype none
module ssch_host #(
   parameter bit TIE_CS_LOW = 1'b0
) (
   // system
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // axi4-lite write
   input wire logic [3:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // axi4-lite read
   input wire logic [3:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // link
   ssch_link_if.host link
);
   import ssch_pkg::*;

   typedef enum logic [2:0] {
      SSCH_H_IDLE = 3'b000,
      SSCH_H_HOLD = 3'b001,
      SSCH_H_RST = 3'b010,
      SSCH_H_SETUP = 3'b011,
      SSCH_H_STROBE = 3'b100,
      SSCH_H_GAP = 3'b101
   } ssch_hst_t;

   localparam int unsigned IN_W = WORD_W + 2;
   logic [IN_W-1:0] s1_q, s2_q, s3_q, filt_q;
   logic busy_prev_q;
   ssch_hst_t st_q;
   logic [7:0] cnt_q, acq_q;
   logic [7:0] div_q;
   logic conv_clk_q;
   logic [NUM_PAIRS-1:0] hold_n_q;
   logic reset_n_q, rd_n_q;
   ssch_sel_t sel_q;
   ssch_word_t last_q;
   logic [3:0] awaddr_q;
   logic [31:0] wdata_q;
   logic aw_ok_q, w_ok_q;
   logic wr_go, wr_ok;

   // link inputs pass three stages; a level moves once two and three agree
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
         filt_q <= '1;
         busy_prev_q <= 1'b1;
      end else if (ce_in) begin
         s1_q <= {link.busy_n, link.data_oe, link.data};
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= (s3_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
         busy_prev_q <= filt_q[IN_W-1];
      end
   end

   // conversion clock from a divider, 128 ns period
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_q <= '0;
         conv_clk_q <= 1'b0;
      end else if (ce_in) begin
         if (div_q == 8'(CONV_HALF_CYC - 1)) begin
            div_q <= '0;
            conv_clk_q <= ~conv_clk_q;
         end else begin
            div_q <= div_q + 8'h1;
         end
      end
   end

   // acquisition guard restarts at each busy rise
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acq_q <= '0;
      end else if (ce_in) begin
         if (filt_q[IN_W-1] && !busy_prev_q) begin
            acq_q <= 8'(ACQ_CYC);
         end else if (acq_q != 8'h0) begin
            acq_q <= acq_q - 8'h1;
         end
      end
   end

   // one link operation at a time keeps reads off hold edges
   assign wr_go = aw_ok_q && w_ok_q && !s_axi_bvalid_out;
   assign wr_ok = (st_q == SSCH_H_IDLE) &&
                  (awaddr_q == REG_READ || (awaddr_q == REG_CTRL && acq_q == 8'h0));

   // link sequencer
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= SSCH_H_IDLE;
         cnt_q <= '0;
         hold_n_q <= '1;
         reset_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         sel_q <= '0;
         last_q <= '0;
      end else if (ce_in) begin
         if (cnt_q != 8'h0) begin
            cnt_q <= cnt_q - 8'h1;
         end
         unique case (st_q)
            SSCH_H_IDLE: begin
               if (wr_go && wr_ok && awaddr_q == REG_CTRL) begin
                  if (wdata_q[CTRL_RESET_BIT]) begin
                     reset_n_q <= 1'b0;
                     cnt_q <= 8'(RESET_LOW_CYC);
                     st_q <= SSCH_H_RST;
                  end else begin
                     hold_n_q <= ~wdata_q[NUM_PAIRS-1:0];
                     cnt_q <= 8'(HOLD_LOW_CYC);
                     st_q <= SSCH_H_HOLD;
                  end
               end else if (wr_go && wr_ok) begin
                  sel_q <= wdata_q[SEL_W-1:0];
                  cnt_q <= 8'(ADDR_SETUP_CYC);
                  st_q <= SSCH_H_SETUP;
               end
            end
            SSCH_H_HOLD: if (cnt_q == 8'h0) begin
               hold_n_q <= '1;
               cnt_q <= 8'(HOLD_HIGH_CYC);
               st_q <= SSCH_H_GAP;
            end
            SSCH_H_RST: if (cnt_q == 8'h0) begin
               reset_n_q <= 1'b1;
               cnt_q <= 8'(FIRST_HOLD_CYC);
               st_q <= SSCH_H_GAP;
            end
            SSCH_H_SETUP: if (cnt_q == 8'h0) begin
               rd_n_q <= 1'b0;
               cnt_q <= 8'(READ_LOW_CYC);
               st_q <= SSCH_H_STROBE;
            end
            SSCH_H_STROBE: if (cnt_q == 8'h0) begin
               last_q <= filt_q[WORD_W] ? filt_q[WORD_W-1:0] : '0;
               rd_n_q <= 1'b1;
               cnt_q <= 8'(READ_HIGH_CYC);
               st_q <= SSCH_H_GAP;
            end
            SSCH_H_GAP: if (cnt_q == 8'h0) begin
               st_q <= SSCH_H_IDLE;
            end
            default: st_q <= SSCH_H_IDLE;
         endcase
      end
   end

   // axi write: address and data in either order, one response after both
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aw_ok_q <= 1'b0;
         w_ok_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         s_axi_awready_out <= 1'b1;
         s_axi_wready_out <= 1'b1;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= RESP_OKAY;
      end else if (ce_in) begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_ok_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_in;
            s_axi_awready_out <= 1'b0;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_ok_q <= 1'b1;
            wdata_q <= s_axi_wstrb_in[0] ? s_axi_wdata_in : 32'h0;
            s_axi_wready_out <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
         end
      end
   end

   // axi read: status word, slverr off the map
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= '0;
         s_axi_rresp_out <= RESP_OKAY;
      end else if (ce_in) begin
         if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= (s_axi_araddr_in == REG_STATUS) ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata_out <= (s_axi_araddr_in == REG_STATUS) ?
               {last_q, 13'h0, (acq_q != 8'h0), (st_q != SSCH_H_IDLE), ~filt_q[IN_W-1]} :
               32'h0;
         end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_arready_out <= 1'b1;
         end
      end
   end

   assign link.pair_sample_request_n = hold_n_q;
   assign link.reset_n = reset_n_q;
   assign link.conv_clk = conv_clk_q;
   assign link.source_select = sel_q;
   assign link.rd_n = rd_n_q;
   assign link.cs_n = TIE_CS_LOW ? 1'b0 : rd_n_q;
endmodule
`default_nettype wire

// File: sim/ssch_properties.sv
/* link pin checker for the scheduler.
   assumes the bench places it beside the interface joining both ends. */
`timescale 1ns/10ps
`default_nettype none
module ssch_properties (
   // system
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // link
   input wire logic [2:0] pair_sample_request_n,
   input wire logic reset_n,
   input wire logic [2:0] source_select,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic busy_n,
   input wire logic [15:0] data,
   input wire logic data_oe
);
   logic [9:0] low_q;
   logic [9:0] gap_q;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   // busy low length and start spacing; gap saturates so it never wraps
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         low_q <= 10'h0;
         gap_q <= 10'h3ff;
      end else begin
         low_q <= busy_n ? 10'h0 : low_q + 10'h1;
         gap_q <= $fell(busy_n) ? 10'h1 : gap_q + {9'h0, gap_q != 10'h3ff};
      end
   end
   property p_oe;
      (rd_n || cs_n) [*6] |-> !data_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("data driven while idle");
   property p_tag;
      (!cs_n && !rd_n && $stable(source_select)) [*8] |-> data_oe &&
         (source_select > 3'h5 ? data == 16'h0 : data[14:12] == source_select);
   endproperty
   a_tag: assert property (p_tag) else $error("wrong word tag");
   property p_hold_rd;
      (!cs_n && !rd_n) [*8] ##1 !rd_n |-> $stable(data);
   endproperty
   a_hold_rd: assert property (p_hold_rd) else $error("word changed in read");
   property p_lreset;
      $fell(reset_n) |-> ##8 busy_n;
   endproperty
   a_lreset: assert property (p_lreset) else $error("busy kept in reset");
   property p_busy;
      $rose(busy_n) && reset_n |-> low_q >= 10'd410 && low_q <= 10'd422;
   endproperty
   a_busy: assert property (p_busy) else $error("busy low length off");
   property p_gap;
      $fell(busy_n) |-> gap_q >= 10'd500;
   endproperty
   a_gap: assert property (p_gap) else $error("starts too close");
   property p_acq;
      $rose(busy_n) |=> busy_n [*8];
   endproperty
   a_acq: assert property (p_acq) else $error("no sampling gap");
   property p_start;
      $fell(pair_sample_request_n[0]) && busy_n |-> ##[1:700] !busy_n;
   endproperty
   a_start: assert property (p_start) else $error("hold never converted");
endmodule
`default_nettype wire

// File: sim/tb_six_channel_sample_scheduler.sv
/* bench: host end and converter end joined by the link, driven over axi4-lite.
   assumes the host register map of the design package. */
`timescale 1ns/10ps
`default_nettype none
module tb_six_channel_sample_scheduler;
   import ssch_pkg::*;
   logic mclk_in = 1'b0, rst_n_in = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = 32'h0, rdata, got;
   logic [1:0] bresp, rresp;
   logic [NUM_CH-1:0][RES_W-1:0] sample = '0;
   logic [NUM_PAIRS-1:0] held;
   int err_count = 0, compares = 0, cycles = 0;
   ssch_link_if link ();
   ssch_device ssch_device_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
      .link(link), .sample_in(sample), .held_out(held));
   ssch_host ssch_host_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .link(link));
   ssch_properties ssch_properties_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .pair_sample_request_n(link.pair_sample_request_n), .reset_n(link.reset_n),
      .source_select(link.source_select), .cs_n(link.cs_n), .rd_n(link.rd_n),
      .busy_n(link.busy_n), .data(link.data), .data_oe(link.data_oe));
   // clock and hang guard
   initial forever #2 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         results();
      end
   end
   task automatic results();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // both channels offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk_in);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      cmp({30'h0, bresp}, {30'h0, e});
      @(posedge mclk_in);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk_in);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      rready <= 1'b0;
      cmp({30'h0, rresp}, {30'h0, e});
      @(posedge mclk_in);
   endtask
   // poll status bits in m; bit0 also waits for held pairs to drain
   task automatic wt(input logic [2:0] m);
      do rd(REG_STATUS, got, RESP_OKAY);
      while ((got[2:0] & m) != 3'h0 || (held & {3{m[0]}}) != 3'h0);
   endtask
   task automatic word(input logic [2:0] s, input logic [15:0] e);
      wr(REG_READ, {29'h0, s}, RESP_OKAY);
      wt(3'h2);
      cmp({16'h0, got[31:16]}, {16'h0, e});
   endtask
   initial begin
      for (int i = 0; i < NUM_CH; i++) sample[i] <= 12'ha00 + 12'(i);
      repeat (5) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      @(posedge mclk_in);
      wr(REG_CTRL, 32'h7, RESP_OKAY);
      wt(3'h7);
      for (int c = 0; c < NUM_CH; c++) word(3'(c), {1'b1, 3'(c), 12'ha00 + 12'(c)});
      word(SEL_CYCLE, 16'h0);
      word(SEL_FIFO, 16'h0);
      $display("test simultaneous done");
      for (int i = 0; i < NUM_CH; i++) sample[i] <= 12'h500 + 12'(i);
      wr(REG_CTRL, 32'h2, RESP_OKAY);
      wt(3'h2);
      for (int i = 0; i < NUM_CH; i++) sample[i] <= 12'h700 + 12'(i);
      wr(REG_CTRL, 32'h2, RESP_OKAY);
      wt(3'h2);
      wr(REG_CTRL, 32'h1, RESP_OKAY);
      wt(3'h7);
      word(3'h2, 16'ha502);
      word(3'h3, 16'hb503);
      word(3'h0, 16'h8700);
      $display("test queue done");
      wr(4'hc, 32'h0, RESP_SLVERR);
      rd(4'hc, got, RESP_SLVERR);
      cmp(got, 32'h0);
      $display("test unmapped done");
      wr(REG_CTRL, 32'h2, RESP_OKAY);
      wt(3'h2);
      wr(REG_CTRL, 32'h8, RESP_OKAY);
      wt(3'h7);
      word(3'h3, 16'h3000);
      word(3'h2, 16'h2000);
      $display("test reset done");
      results();
   end
endmodule
`default_nettype wire
